// file: design/frac_n_ctrl_defs.vh
// constants for the fractional-n divider control block
// Behaviour
// - pin-function select equal to 1 puts lock indication on the shared pin.
// - serial read data takes the shared pin during a read, then lock returns.
// - force-lock bit set keeps lock on the pin and disables read-back.
// - phase comparator gain is raised while phase error is large.
// - six-bit output divider selects divide by 1 or even values 2 to 62.
// - oscillator band tuning runs automatically within 2050 to 4100 MHz.
// - integer mode keeps the delta-sigma modulator idle.
// - integer mode accepts divide values 16 to 2^19-1.
// - oscillator frequency is reference over R times integer plus fraction.
// - fraction equals fractional word over 2^24.
// - fractional mode limits integer divide to 20 through 524284.
// - integer word is 19 bits, fractional word 24 bits.
// - modulator modulus is fixed at 2^24.
// - exact mode register sets equal steps across an integer boundary.
// - hit windows count up; threshold declares lock; a miss clears it.
`ifndef FRAC_N_CTRL_DEFS_VH
`define FRAC_N_CTRL_DEFS_VH
`define ADDR_REF_DIV     5'h02
`define ADDR_INT_WORD    5'h03
`define ADDR_FRAC_WORD   5'h04
`define ADDR_MODE        5'h06
`define ADDR_LOCK_CFG    5'h07
`define ADDR_CP          5'h09
`define ADDR_EXACT       5'h0c
`define ADDR_PIN_FN      5'h0f
`define ADDR_STATUS      5'h12
`define ADDR_OUT_DIV     5'h16
`define MODE_FRAC_EN     11
`define MODE_BYPASS      7
`define PIN_FORCE_LOCK   6
`define PIN_FN_LOCK      5'h01
`define INT_MIN_INTEGER  19'h00010
`define INT_MIN_FRAC     19'h00014
`define INT_MAX_FRAC     19'h7fffc
`define VCO_BAND_LO_MHZ  2050
`define VCO_BAND_HI_MHZ  4100
`define BAND_CODE_MAX    8'hff
`define SLIP_ERR_LIMIT   4'h3
`endif

// file: design/frac_n_divider_control.v
// digital control for a fractional-n synthesizer feedback path
`timescale 1ns/1ps
`default_nettype none
`include "frac_n_ctrl_defs.vh"
module frac_n_divider_control (
    input  wire        sys_clk,
    input  wire        resetn,
    // register write/read port from the serial-port engine
    input  wire        regWrite,
    input  wire        regRead,
    input  wire [4:0]  regAddr,
    input  wire [23:0] regWdata,
    output reg  [23:0] regRdata,
    // serial engine: read shift active and its data bit
    input  wire        readActive,
    input  wire        serialReadOut,
    // window results from the lock window comparator, same clock
    input  wire        windowDone,
    input  wire        windowHit,
    // band comparator and phase error magnitude
    input  wire        vcoTooFast,
    input  wire        vcoTooSlow,
    input  wire [3:0]  phaseErrMag,
    output reg         lockOrSerialOutPin,
    output wire        lockIndication,
    output reg  [18:0] feedbackInt,
    output reg         feedbackCarry,
    output reg  [5:0]  outDivRatio,
    output reg  [7:0]  bandCode,
    output reg         cycleSlipGuard
);
    // =====================================================
    // registers
    reg [13:0] refDiv_q;
    reg [18:0] intWord_q;
    reg [23:0] fracWord_q;
    reg [11:0] mode_q;
    reg [11:0] lockCfg_q;
    reg [22:0] cp_q;
    reg [23:0] exact_q;
    reg [6:0]  pinFn_q;
    reg [5:0]  outDiv_q;
    reg [7:0]  lockCnt_q;
    reg        locked_q;
    reg [23:0] acc_q;
    reg [23:0] stepCnt_q;
    reg        wasFrac_q;

    wire fracMode = mode_q[`MODE_FRAC_EN] & ~mode_q[`MODE_BYPASS];
    assign lockIndication = locked_q;

    // clamp the integer word into the legal range of the current mode
    function [18:0] clampInt;
        input [18:0] v;
        input        frac;
        begin
            if (frac && v < `INT_MIN_FRAC)
                clampInt = `INT_MIN_FRAC;
            else if (frac && v > `INT_MAX_FRAC)
                clampInt = `INT_MAX_FRAC;
            else if (!frac && v < `INT_MIN_INTEGER)
                clampInt = `INT_MIN_INTEGER;
            else
                clampInt = v;
        end
    endfunction

    // =====================================================
    // register writes
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            refDiv_q   <= 14'h0001;
            intWord_q  <= 19'h00014;
            fracWord_q <= 24'h000000;
            mode_q     <= 12'h000;
            lockCfg_q  <= 12'h000;
            cp_q       <= 23'h000000;
            exact_q    <= 24'h000000;
            pinFn_q    <= 7'h00;
            outDiv_q   <= 6'h00;
        end else if (regWrite) begin
            case (regAddr)
                `ADDR_REF_DIV:   refDiv_q   <= regWdata[13:0];
                `ADDR_INT_WORD:  intWord_q  <= regWdata[18:0];
                `ADDR_FRAC_WORD: fracWord_q <= regWdata[23:0];
                `ADDR_MODE:      mode_q     <= regWdata[11:0];
                `ADDR_LOCK_CFG:  lockCfg_q  <= regWdata[11:0];
                // host keeps offset zero in integer mode
                `ADDR_CP:        cp_q       <= regWdata[22:0];
                `ADDR_EXACT:     exact_q    <= regWdata[23:0];
                `ADDR_PIN_FN:    pinFn_q    <= regWdata[6:0];
                `ADDR_OUT_DIV:   outDiv_q   <= regWdata[5:0];
                default: ;
            endcase
        end
    end

    // =====================================================
    // register read-back
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 24'h000000;
        end else if (regRead) begin
            case (regAddr)
                `ADDR_REF_DIV:   regRdata <= {10'h000, refDiv_q};
                `ADDR_INT_WORD:  regRdata <= {5'h00, intWord_q};
                `ADDR_FRAC_WORD: regRdata <= fracWord_q;
                `ADDR_MODE:      regRdata <= {12'h000, mode_q};
                `ADDR_LOCK_CFG:  regRdata <= {12'h000, lockCfg_q};
                `ADDR_CP:        regRdata <= {1'b0, cp_q};
                `ADDR_EXACT:     regRdata <= exact_q;
                `ADDR_PIN_FN:    regRdata <= {17'h00000, pinFn_q};
                `ADDR_STATUS:    regRdata <= {22'h000000, locked_q, 1'b0};
                `ADDR_OUT_DIV:   regRdata <= {18'h00000, outDiv_q};
                default:         regRdata <= 24'h000000;
            endcase
        end
    end

    // =====================================================
    // lock detect counter
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lockCnt_q <= 8'h00;
            locked_q  <= 1'b0;
        end else if (!lockCfg_q[11]) begin
            lockCnt_q <= 8'h00;
            locked_q  <= 1'b0;
        end else if (windowDone) begin
            // hit counts, miss clears at once
            if (windowHit) begin
                if (lockCnt_q != 8'hff)
                    lockCnt_q <= lockCnt_q + 8'h01;
                if (lockCnt_q + 8'h01 >= {5'h00, lockCfg_q[2:0]})
                    locked_q <= 1'b1;
            end else begin
                lockCnt_q <= 8'h00;
                locked_q  <= 1'b0;
            end
        end
    end

    // =====================================================
    // shared pin
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lockOrSerialOutPin <= 1'b0;
        end else if (pinFn_q[`PIN_FORCE_LOCK]) begin
            lockOrSerialOutPin <= locked_q;
        end else if (readActive) begin
            lockOrSerialOutPin <= serialReadOut;
        end else if (pinFn_q[4:0] == `PIN_FN_LOCK) begin
            lockOrSerialOutPin <= locked_q;
        end else begin
            lockOrSerialOutPin <= 1'b0;
        end
    end

    // =====================================================
    // delta-sigma accumulator, modulus 2^24
    wire [24:0] accSum = {1'b0, acc_q} + {1'b0, fracWord_q};
    wire        exactOn = exact_q != 24'h000000;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q         <= 24'h000000;
            stepCnt_q     <= 24'h000000;
            feedbackInt   <= 19'h00014;
            feedbackCarry <= 1'b0;
            wasFrac_q     <= 1'b0;
        end else begin
            wasFrac_q   <= fracMode;
            feedbackInt <= clampInt(intWord_q, fracMode);
            if (!fracMode) begin
                acc_q         <= 24'h000000;
                stepCnt_q     <= 24'h000000;
                feedbackCarry <= 1'b0;
            end else if (!wasFrac_q) begin
                acc_q         <= 24'h000000;
                stepCnt_q     <= 24'h000000;
                feedbackCarry <= 1'b0;
            end else if (exactOn && stepCnt_q + 24'h000001 >= exact_q) begin
                // pattern restarts after exact step count
                stepCnt_q     <= 24'h000000;
                acc_q         <= 24'h000000;
                feedbackCarry <= accSum[24];
            end else begin
                stepCnt_q     <= stepCnt_q + 24'h000001;
                acc_q         <= accSum[23:0];
                feedbackCarry <= accSum[24];
            end
        end
    end

    // =====================================================
    // output divider, band tuning, slip guard
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            outDivRatio    <= 6'h01;
            bandCode       <= 8'h80;
            cycleSlipGuard <= 1'b0;
        end else begin
            // divide by 1 or even 2..62
            if (outDiv_q <= 6'h01)
                outDivRatio <= 6'h01;
            else
                outDivRatio <= {outDiv_q[5:1], 1'b0};
            // automatic band search, no host action
            if (vcoTooSlow && bandCode != `BAND_CODE_MAX)
                bandCode <= bandCode + 8'h01;
            else if (vcoTooFast && bandCode != 8'h00)
                bandCode <= bandCode - 8'h01;
            // extra gain on large phase error
            cycleSlipGuard <= phaseErrMag > `SLIP_ERR_LIMIT;
        end
    end
endmodule
`default_nettype wire

// file: test/frac_n_ctrl_monitor.sv
// port checker for the divider control block
`timescale 1ns/1ps
`default_nettype none
module frac_n_ctrl_monitor (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        regWrite,
    input wire logic [4:0]  regAddr,
    input wire logic [23:0] regWdata,
    input wire logic        readActive,
    input wire logic        serialReadOut,
    input wire logic        windowDone,
    input wire logic        windowHit,
    input wire logic [3:0]  phaseErrMag,
    input wire logic        lockOrSerialOutPin,
    input wire logic        lockIndication,
    input wire logic [5:0]  outDivRatio,
    input wire logic        cycleSlipGuard
);
    logic [6:0] pinCfg_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ========================================
    // pin-function shadow, seen only via writes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            pinCfg_q <= 7'h00;
        else if (regWrite && regAddr == 5'h0f)
            pinCfg_q <= regWdata[6:0];
    end
    lock_pin_a: assert property (
        !pinCfg_q[6] && !readActive && pinCfg_q[4:0] == 5'h01
        |=> lockOrSerialOutPin == $past(lockIndication)) else $error("lock pin");
    read_pin_a: assert property (
        !pinCfg_q[6] && readActive
        |=> lockOrSerialOutPin == $past(serialReadOut)) else $error("read pin");
    force_pin_a: assert property (
        pinCfg_q[6] |=> lockOrSerialOutPin == $past(lockIndication))
        else $error("force pin");
    slip_gain_a: assert property (
        1'b1 |=> cycleSlipGuard == ($past(phaseErrMag) > 4'h3))
        else $error("slip guard");
    div_even_a: assert property (
        outDivRatio == 6'h01 || (outDivRatio != 6'h00 && !outDivRatio[0]))
        else $error("out div");
    lock_clear_a: assert property (
        windowDone && !windowHit |=> !lockIndication) else $error("miss");
    lock_rise_a: assert property (
        $rose(lockIndication) |-> $past(windowDone && windowHit))
        else $error("lock rise");
    lock_hold_a: assert property (
        !windowDone && !regWrite && !$past(regWrite)
        |=> $stable(lockIndication)) else $error("lock hold");
    cover property (windowDone && windowHit ##1 $rose(lockIndication));
    cover property (pinCfg_q[6] && readActive);
    cover property (windowDone && !windowHit ##1 $fell(lockIndication));
endmodule
bind frac_n_divider_control frac_n_ctrl_monitor u_mon (
    .sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .readActive(readActive),
    .serialReadOut(serialReadOut), .windowDone(windowDone),
    .windowHit(windowHit), .phaseErrMag(phaseErrMag),
    .lockOrSerialOutPin(lockOrSerialOutPin),
    .lockIndication(lockIndication), .outDivRatio(outDivRatio),
    .cycleSlipGuard(cycleSlipGuard));
`default_nettype wire

// file: test/host_port_model.sv
// host side: register port and serial read shift
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input  wire logic        sys_clk,
    input  wire logic [23:0] regRdata,
    output var  logic        regWrite,
    output var  logic        regRead,
    output var  logic [4:0]  regAddr,
    output var  logic [23:0] regWdata,
    output var  logic        readActive,
    output var  logic        serialReadOut
);
    initial {regWrite, regRead, regAddr, regWdata} = '0;
    initial {readActive, serialReadOut} = 2'b00;
    // released lines carry the inverse, never the old value
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(negedge sys_clk);
        {regWrite, regAddr, regWdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [4:0] a, output logic [23:0] q);
        @(negedge sys_clk);
        {regRead, regAddr} = {1'b1, a};
        @(negedge sys_clk);
        {regRead, regAddr} = {1'b0, ~a};
        q = regRdata;
    endtask
    task automatic readShift(input logic on, input logic b);
        @(negedge sys_clk);
        readActive = on;
        serialReadOut = on ? b : ~serialReadOut;
    endtask
    task automatic intMode();
        wr(5'h06, 24'h000080);
        wr(5'h09, 24'h000000);
    endtask
    task automatic fracMode();
        wr(5'h06, 24'h000800);
    endtask
endmodule
`default_nettype wire

// file: test/frac_n_divider_control_tb.sv
// self-checking bench for the divider control block
`timescale 1ns/1ps
`default_nettype none
module frac_n_divider_control_tb;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        windowDone = 1'b0;
    logic        windowHit = 1'b0;
    logic [3:0]  phaseErrMag = 4'h0;
    logic        vcoFast = 1'b0;
    logic        vcoSlow = 1'b0;
    logic [7:0]  band;
    logic        regWrite, regRead, readActive, serialReadOut;
    logic        pin, lockInd, carry, guard;
    logic [4:0]  regAddr;
    logic [23:0] regWdata, regRdata, q;
    logic [18:0] feedbackInt;
    logic [5:0]  outDivRatio;
    logic [5:0]  dc [6] = '{6'd0, 6'd1, 6'd2, 6'd3, 6'd62, 6'd63};
    logic [5:0]  de [6] = '{6'd1, 6'd1, 6'd2, 6'd2, 6'd62, 6'd62};
    int          failures = 0;
    int          n_compared = 0;
    int          n;
    always #2.5 sys_clk = ~sys_clk;
    frac_n_divider_control u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .readActive(readActive),
        .serialReadOut(serialReadOut), .windowDone(windowDone),
        .windowHit(windowHit), .vcoTooFast(vcoFast), .vcoTooSlow(vcoSlow),
        .phaseErrMag(phaseErrMag), .lockOrSerialOutPin(pin),
        .lockIndication(lockInd), .feedbackInt(feedbackInt),
        .feedbackCarry(carry), .outDivRatio(outDivRatio), .bandCode(band),
        .cycleSlipGuard(guard));
    host_port_model u_host (
        .sys_clk(sys_clk), .regRdata(regRdata), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .readActive(readActive), .serialReadOut(serialReadOut));
    task automatic chk(input string nm, input logic [23:0] e, g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // write, then let the registered outputs settle
    task automatic set(input logic [4:0] a, input logic [23:0] d);
        u_host.wr(a, d);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic win(input logic h);
        @(negedge sys_clk);
        {windowDone, windowHit} = {1'b1, h};
        @(negedge sys_clk);
        windowDone = 1'b0;
    endtask
    task automatic carries(input logic [23:0] e);
        n = 0;
        repeat (16) begin
            @(negedge sys_clk);
            n += int'(carry);
        end
        chk("carries", e, 24'(n));
    endtask
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        u_host.rd(5'h03, q);
        chk("int reset", 24'h000014, q);
        u_host.intMode();
        set(5'h03, 24'h000005);
        chk("int floor", 24'h000010, {5'h0, feedbackInt});
        u_host.fracMode();
        set(5'h03, 24'h07ffff);
        chk("frac ceil", 24'h07fffc, {5'h0, feedbackInt});
        set(5'h03, 24'h000010);
        chk("frac floor", 24'h000014, {5'h0, feedbackInt});
        set(5'h04, 24'h800000);
        u_host.rd(5'h04, q);
        chk("frac word", 24'h800000, q);
        carries(24'd8);
        set(5'h0c, 24'h000002);
        set(5'h04, 24'h400000);
        carries(24'd0);
        set(5'h0c, 24'h000000);
        set(5'h04, 24'h800000);
        u_host.intMode();
        carries(24'd0);
        for (int i = 0; i < 6; i++) begin
            set(5'h16, {18'h0, dc[i]});
            chk("out div", {18'h0, de[i]}, {18'h0, outDivRatio});
        end
        set(5'h0f, 24'h000001);
        set(5'h07, 24'h000803);
        win(1'b1);
        win(1'b1);
        chk("early lock", 24'h0, {23'h0, lockInd});
        win(1'b1);
        @(negedge sys_clk);
        chk("lock pin", 24'h1, {23'h0, pin});
        u_host.rd(5'h12, q);
        chk("lock status", 24'h000002, q);
        u_host.readShift(1'b1, 1'b0);
        @(negedge sys_clk);
        chk("read pin", 24'h0, {23'h0, pin});
        u_host.readShift(1'b0, 1'b0);
        @(negedge sys_clk);
        chk("pin back", 24'h1, {23'h0, pin});
        set(5'h0f, 24'h000041);
        u_host.readShift(1'b1, 1'b0);
        @(negedge sys_clk);
        chk("forced pin", 24'h1, {23'h0, pin});
        u_host.readShift(1'b0, 1'b0);
        win(1'b0);
        chk("miss", 24'h0, {23'h0, lockInd});
        phaseErrMag = 4'h4;
        @(negedge sys_clk);
        chk("guard on", 24'h1, {23'h0, guard});
        phaseErrMag = 4'h3;
        @(negedge sys_clk);
        chk("guard off", 24'h0, {23'h0, guard});
        chk("band reset", 24'h000080, {16'h0, band});
        vcoSlow = 1'b1;
        repeat (3) @(negedge sys_clk);
        vcoSlow = 1'b0;
        chk("band up", 24'h000083, {16'h0, band});
        vcoFast = 1'b1;
        @(negedge sys_clk);
        vcoFast = 1'b0;
        chk("band down", 24'h000082, {16'h0, band});
        wrap_up();
    end
endmodule
`default_nettype wire
